// ==== hw/tdl_logger.sv ====
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ns
`include "tdl_consts.svh"
module tdl_logger #(
   parameter int MS_CYCLES = `TDL_MS_NS / `TDL_CLK_NS
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        reset,
   // register port
   input  wire logic [15:0] reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_write,
   input  wire logic        reg_read,
   output      logic [15:0] reg_rdata,
   // monitored parameters
   input  wire logic [31:0] supply_fault_word,
   input  wire logic [15:0] dc_voltage,
   input  wire logic [15:0] dc_current,
   input  wire logic [28:0] fault_pulse,
   // wall time
   input  wire logic [31:0] time_stamp,
   input  wire logic [31:0] date_stamp,
   // interrupt
   output      logic        irq
);

   tdl_pkg::tdl_regs_s      r;
   tdl_pkg::tdl_regs_s      n;
   logic                    hit1;
   logic                    hit2;
   logic                    fire;
   logic                    tick_ms;
   logic                    sample_now;
   logic                    running;
   logic [`TDL_EV_W-1:0]    ev_set;
   logic [`TDL_EV_W-1:0]    ev_clr;
   logic [10:0]             pct_prod;
   logic [`TDL_PTR_W:0]     tgt;
   logic [`TDL_PTR_W-1:0]   rd_idx;
   logic [63:0]             rd_word;
   logic [8:0]              fidx;
   logic [15:0]             woff;
   logic [15:0]             status;

   // ----------------------------------------
   // trigger unit compare
   // ----------------------------------------
   function automatic logic unit_hit(
      input logic [15:0] kind,
      input logic [15:0] pick,
      input logic [31:0] mask,
      input logic [31:0] thr,
      input logic [31:0] fw,
      input logic [15:0] dv
   );
      logic [31:0] src;
      logic [31:0] m;
      logic        h;
      src = 32'h0000_0000;
      if (pick == `TDL_SRC_FLT) begin
         src = fw;
      end else if (pick == `TDL_SRC_DCV) begin
         src = {16'h0000, dv};
      end
      m = src & mask;
      unique case (kind[1:0])
         2'h0: h = m < thr;
         2'h1: h = m > thr;
         2'h2: h = m == thr;
         2'h3: h = m != thr;
      endcase
      return h;
   endfunction

   // ----------------------------------------
   // next-state logic
   // ----------------------------------------
   always_comb begin
      n          = r;
      ev_set     = '0;
      ev_clr     = '0;
      sample_now = 1'b0;
      pct_prod   = 11'h000;
      tgt        = '0;
      rd_idx     = '0;
      rd_word    = 64'h0;
      fidx       = 9'h000;
      woff       = reg_addr - `TDL_A_WIN;
      n.rdata    = 16'h0000;

      hit1 = unit_hit(r.kind1, r.pick1, r.mask1, r.thr1,
                      supply_fault_word, dc_voltage);
      hit2 = unit_hit(r.kind2, r.pick2, r.mask2, r.thr2,
                      supply_fault_word, dc_voltage);

      unique case (r.mode[1:0])
         2'h0: fire = 1'b0;
         2'h1: fire = r.start & hit1;
         2'h2: fire = r.start & (hit1 | hit2);
         2'h3: fire = r.start & hit1 & hit2;
      endcase

      unique case (r.st)
         tdl_pkg::ST_IDLE:  status = 16'h0000;
         tdl_pkg::ST_ARMED: status = 16'h0001;
         tdl_pkg::ST_POST:  status = 16'h0002;
         tdl_pkg::ST_CONT:  status = 16'h0002;
         tdl_pkg::ST_DONE:  status = 16'h0003;
         default:           status = 16'h0000;
      endcase

      // sample pacing; period 0 behaves as 1 ms
      running = (r.st == tdl_pkg::ST_ARMED) ||
                (r.st == tdl_pkg::ST_POST)  ||
                (r.st == tdl_pkg::ST_CONT);
      tick_ms = r.ms_cnt == `TDL_MS_W'(MS_CYCLES - 1);
      if (!running) begin
         n.ms_cnt  = '0;
         n.per_cnt = 16'h0000;
      end else if (tick_ms) begin
         n.ms_cnt = '0;
         if (r.per_cnt + 16'h0001 >= r.period) begin
            n.per_cnt  = 16'h0000;
            sample_now = 1'b1;
         end else begin
            n.per_cnt = r.per_cnt + 16'h0001;
         end
      end else begin
         n.ms_cnt = r.ms_cnt + `TDL_MS_W'(1);
      end

      // post share of the depth, percent truncated
      if (r.pct >= `TDL_PCT_FULL) begin
         tgt = (`TDL_PTR_W+1)'(`TDL_DEPTH);
      end else begin
         pct_prod = {r.pct[6:0], 4'h0};
         tgt      = (`TDL_PTR_W+1)'(pct_prod / 11'h064);
      end

      // circular capture; buffer stays frozen outside running
      if (sample_now) begin
         n.mem[r.wr_ptr] = {supply_fault_word, dc_voltage,
                            dc_current};
         n.wr_ptr = r.wr_ptr + `TDL_PTR_W'(1);
         if (r.count != (`TDL_PTR_W+1)'(`TDL_DEPTH)) begin
            n.count = r.count + (`TDL_PTR_W+1)'(1);
         end
      end

      // capture sequence
      unique case (r.st)
         tdl_pkg::ST_IDLE: begin
            if (r.start) begin
               n.wr_ptr    = '0;
               n.count     = '0;
               n.post_done = '0;
               n.post_tgt  = '0;
               if (r.mode[1:0] == 2'h0) begin
                  n.st = tdl_pkg::ST_CONT;
               end else begin
                  n.st = tdl_pkg::ST_ARMED;
               end
            end
         end
         tdl_pkg::ST_CONT: begin
            if (!r.start) begin
               n.st = tdl_pkg::ST_IDLE;
            end
         end
         tdl_pkg::ST_ARMED: begin
            if (!r.start) begin
               n.st = tdl_pkg::ST_IDLE;
            end else if (fire) begin
               n.post_tgt  = tgt;
               n.post_done = '0;
               n.trig_time = time_stamp;
               n.trig_date = date_stamp;
               ev_set[`TDL_EV_TRIG] = 1'b1;
               if (tgt == '0) begin
                  n.st = tdl_pkg::ST_DONE;
                  ev_set[`TDL_EV_DONE] = 1'b1;
               end else begin
                  n.st = tdl_pkg::ST_POST;
               end
            end
         end
         tdl_pkg::ST_POST: begin
            if (!r.start) begin
               n.st = tdl_pkg::ST_IDLE;
            end else if (sample_now) begin
               // stop at post count and freeze
               n.post_done = r.post_done + (`TDL_PTR_W+1)'(1);
               if (r.post_done + (`TDL_PTR_W+1)'(1) == r.post_tgt)
               begin
                  n.st = tdl_pkg::ST_DONE;
                  ev_set[`TDL_EV_DONE] = 1'b1;
               end
            end
         end
         tdl_pkg::ST_DONE: begin
            if (!r.start) begin
               n.st = tdl_pkg::ST_IDLE;
            end
         end
         default: n.st = tdl_pkg::ST_IDLE;
      endcase

      for (int f = 0; f < `TDL_FAULTS; f++) begin
         if (fault_pulse[f] && r.fcnt[f] != 16'hFFFF) begin
            n.fcnt[f] = r.fcnt[f] + 16'h0001;
         end
      end
      if (|fault_pulse) begin
         ev_set[`TDL_EV_FAULT] = 1'b1;
      end

      // register writes
      if (reg_write) begin
         unique case (reg_addr)
            `TDL_A_START:     n.start = reg_wdata[0];
            `TDL_A_POSTPCT:   n.pct = reg_wdata;
            `TDL_A_PERIOD:    n.period = reg_wdata;
            `TDL_A_SEL_LO:    n.sel[31:16] = reg_wdata;
            `TDL_A_SEL_LO+1:  n.sel[15:0] = reg_wdata;
            `TDL_A_SEL_HI:    n.sel[63:48] = reg_wdata;
            `TDL_A_SEL_HI+1:  n.sel[47:32] = reg_wdata;
            `TDL_A_MODE:      n.mode = reg_wdata;
            `TDL_A_K1:        n.kind1 = reg_wdata;
            `TDL_A_P1:        n.pick1 = reg_wdata;
            `TDL_A_M1:        n.mask1[31:16] = reg_wdata;
            `TDL_A_M1+1:      n.mask1[15:0] = reg_wdata;
            `TDL_A_T1:        n.thr1[31:16] = reg_wdata;
            `TDL_A_T1+1:      n.thr1[15:0] = reg_wdata;
            `TDL_A_K2:        n.kind2 = reg_wdata;
            `TDL_A_P2:        n.pick2 = reg_wdata;
            `TDL_A_M2:        n.mask2[31:16] = reg_wdata;
            `TDL_A_M2+1:      n.mask2[15:0] = reg_wdata;
            `TDL_A_T2:        n.thr2[31:16] = reg_wdata;
            `TDL_A_T2+1:      n.thr2[15:0] = reg_wdata;
            `TDL_A_EV_CLR:    ev_clr = reg_wdata[`TDL_EV_W-1:0];
            `TDL_A_EV_EN:     n.ev_en = reg_wdata[`TDL_EV_W-1:0];
            `TDL_A_HDR: begin
               if (reg_wdata == 16'h0001) begin
                  n.win     = '0;
                  n.win[0]  = r.trig_time[31:16];
                  n.win[1]  = r.trig_time[15:0];
                  n.win[2]  = r.trig_date[31:16];
                  n.win[3]  = r.trig_date[15:0];
                  n.win[4]  = r.sel[31:16];
                  n.win[5]  = r.sel[15:0];
                  n.win[6]  = r.sel[63:48];
                  n.win[7]  = r.sel[47:32];
                  n.win[8]  = 16'(r.count);
                  n.win[9]  = `TDL_SWORDS;
                  n.win[10] = r.period;
                  n.win[11] = 16'(r.post_done);
               end
            end
            `TDL_A_SAMPLE: begin
               n.win = '0;
               // index 0 is the oldest kept sample
               if (reg_wdata < 16'(r.count)) begin
                  rd_idx  = r.wr_ptr - r.count[`TDL_PTR_W-1:0]
                            + reg_wdata[`TDL_PTR_W-1:0];
                  rd_word = r.mem[rd_idx];
                  n.win[0] = rd_word[63:48];
                  n.win[1] = rd_word[47:32];
                  n.win[2] = rd_word[31:16];
                  n.win[3] = rd_word[15:0];
               end
            end
            `TDL_A_FCOUNT: begin
               n.win = '0;
               // low byte first, high byte how many
               for (int i = 0; i < `TDL_WIN_LEN; i++) begin
                  fidx = {1'b0, reg_wdata[7:0]} + 9'(i);
                  if (9'(i) < {1'b0, reg_wdata[15:8]} &&
                      fidx < 9'(`TDL_FAULTS)) begin
                     n.win[i] = r.fcnt[fidx[4:0]];
                  end
               end
            end
            default: ;
         endcase
      end

      // sticky events; a set in the clearing cycle survives
      n.ev_stat = (r.ev_stat & ~ev_clr) | ev_set;

      // register reads, answered next cycle
      if (reg_read) begin
         unique case (reg_addr)
            `TDL_A_START:     n.rdata = {15'h0000, r.start};
            `TDL_A_POSTPCT:   n.rdata = r.pct;
            `TDL_A_PERIOD:    n.rdata = r.period;
            `TDL_A_SEL_LO:    n.rdata = r.sel[31:16];
            `TDL_A_SEL_LO+1:  n.rdata = r.sel[15:0];
            `TDL_A_SEL_HI:    n.rdata = r.sel[63:48];
            `TDL_A_SEL_HI+1:  n.rdata = r.sel[47:32];
            `TDL_A_MODE:      n.rdata = r.mode;
            `TDL_A_K1:        n.rdata = r.kind1;
            `TDL_A_P1:        n.rdata = r.pick1;
            `TDL_A_M1:        n.rdata = r.mask1[31:16];
            `TDL_A_M1+1:      n.rdata = r.mask1[15:0];
            `TDL_A_T1:        n.rdata = r.thr1[31:16];
            `TDL_A_T1+1:      n.rdata = r.thr1[15:0];
            `TDL_A_K2:        n.rdata = r.kind2;
            `TDL_A_P2:        n.rdata = r.pick2;
            `TDL_A_M2:        n.rdata = r.mask2[31:16];
            `TDL_A_M2+1:      n.rdata = r.mask2[15:0];
            `TDL_A_T2:        n.rdata = r.thr2[31:16];
            `TDL_A_T2+1:      n.rdata = r.thr2[15:0];
            `TDL_A_STATUS:    n.rdata = status;
            `TDL_A_EV_STAT:
               n.rdata = {13'h0000, r.ev_stat};
            `TDL_A_EV_EN:
               n.rdata = {13'h0000, r.ev_en};
            default: begin
               if (woff < 16'(`TDL_WIN_LEN)) begin
                  n.rdata = r.win[woff[4:0]];
               end
            end
         endcase
      end
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign reg_rdata = r.rdata;
   assign irq       = |(r.ev_stat & r.ev_en);

endmodule

// ==== hw/tdl_consts.svh ====
`ifndef TDL_CONSTS_SVH
`define TDL_CONSTS_SVH
// ----------------------------------------
// register word addresses
// ----------------------------------------
`define TDL_A_START   16'h9DED
`define TDL_A_POSTPCT 16'h9DEE
`define TDL_A_PERIOD  16'h9DEF
`define TDL_A_SEL_LO  16'h9DF0
`define TDL_A_SEL_HI  16'h9DF2
`define TDL_A_MODE    16'h9DF4
`define TDL_A_K1      16'h9DF5
`define TDL_A_P1      16'h9DF6
`define TDL_A_M1      16'h9DF7
`define TDL_A_T1      16'h9DF9
`define TDL_A_K2      16'h9DFB
`define TDL_A_P2      16'h9DFC
`define TDL_A_M2      16'h9DFD
`define TDL_A_T2      16'h9DFF
`define TDL_A_STATUS  16'h9E01
`define TDL_A_HDR     16'h9E02
`define TDL_A_SAMPLE  16'h9E03
`define TDL_A_FCOUNT  16'h9E09
`define TDL_A_WIN     16'h9E0C
`define TDL_A_EV_STAT 16'h9E30
`define TDL_A_EV_CLR  16'h9E31
`define TDL_A_EV_EN   16'h9E32
// ----------------------------------------
// sizes, codes and timing
// ----------------------------------------
`define TDL_WIN_LEN   29
`define TDL_HDR_LEN   12
`define TDL_FAULTS    29
`define TDL_DEPTH     16
`define TDL_PTR_W     4
`define TDL_SWORDS    16'h0004
`define TDL_PCT_FULL  16'h0064
`define TDL_SRC_FLT   16'h0001
`define TDL_SRC_DCV   16'h0003
`define TDL_EV_TRIG   0
`define TDL_EV_DONE   1
`define TDL_EV_FAULT  2
`define TDL_EV_W      3
`define TDL_MS_W      17
`define TDL_CLK_NS    10
`define TDL_MS_NS     1000000
`endif

// ==== hw/tdl_pkg.sv ====
package tdl_pkg;
`include "tdl_consts.svh"
   typedef enum logic [2:0] {
      ST_IDLE  = 3'h0,
      ST_ARMED = 3'h1,
      ST_POST  = 3'h2,
      ST_DONE  = 3'h3,
      ST_CONT  = 3'h4
   } tdl_state_e;

   typedef logic [15:0] tdl_word_t;

   typedef struct packed {
      tdl_state_e                        st;
      logic                              start;
      tdl_word_t                         pct;
      tdl_word_t                         period;
      tdl_word_t                         mode;
      logic [63:0]                       sel;
      tdl_word_t                         kind1;
      tdl_word_t                         pick1;
      logic [31:0]                       mask1;
      logic [31:0]                       thr1;
      tdl_word_t                         kind2;
      tdl_word_t                         pick2;
      logic [31:0]                       mask2;
      logic [31:0]                       thr2;
      logic [`TDL_MS_W-1:0]              ms_cnt;
      tdl_word_t                         per_cnt;
      logic [`TDL_PTR_W-1:0]             wr_ptr;
      logic [`TDL_PTR_W:0]               count;
      logic [`TDL_PTR_W:0]               post_tgt;
      logic [`TDL_PTR_W:0]               post_done;
      logic [31:0]                       trig_time;
      logic [31:0]                       trig_date;
      logic [`TDL_DEPTH-1:0][63:0]       mem;
      logic [`TDL_FAULTS-1:0][15:0]      fcnt;
      logic [`TDL_WIN_LEN-1:0][15:0]     win;
      logic [`TDL_EV_W-1:0]              ev_stat;
      logic [`TDL_EV_W-1:0]              ev_en;
      tdl_word_t                         rdata;
   } tdl_regs_s;
endpackage

// ==== bench/tdl_assertions.sv ====
`timescale 1ns/1ns
`include "tdl_consts.svh"
module tdl_assertions #(
   parameter int MS_CYCLES = 4
) (
   // clock and reset
   input wire logic        clk,
   input wire logic        reset,
   // register port
   input wire logic [15:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic        reg_write,
   input wire logic        reg_read,
   input wire logic [15:0] reg_rdata,
   // monitored parameters
   input wire logic [31:0] supply_fault_word,
   input wire logic [15:0] dc_voltage,
   input wire logic [15:0] dc_current,
   input wire logic [28:0] fault_pulse,
   input wire logic [31:0] time_stamp,
   input wire logic [31:0] date_stamp,
   // interrupt
   input wire logic        irq
);
   // ----------------------------------------
   // shadow of what software last asked for
   // ----------------------------------------
   logic [2:0] en_reg;
   logic       idle_reg;
   logic [1:0] lk_reg;
   logic       win_rd;
   assign win_rd = reg_read && reg_addr >= `TDL_A_WIN
      && reg_addr < `TDL_A_WIN + `TDL_WIN_LEN;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         en_reg   <= 3'h0;
         idle_reg <= 1'b1;
         lk_reg   <= 2'h0;
      end else if (reg_write) begin
         case (reg_addr)
            `TDL_A_EV_EN:  en_reg <= reg_wdata[2:0];
            `TDL_A_START:  idle_reg <= ~reg_wdata[0];
            `TDL_A_HDR:    lk_reg <= (reg_wdata == 16'h0001) ? 2'h1 : lk_reg;
            `TDL_A_SAMPLE: lk_reg <= (reg_wdata > 16'h000F) ? 2'h2 : 2'h0;
            `TDL_A_FCOUNT: lk_reg <= (reg_wdata[15:8] == 8'h00) ? 2'h3 : 2'h0;
            default: ;
         endcase
      end
   end
   // ----------------------------------------
   // properties
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   a_rdata_idle: assert property (!reg_read |=> reg_rdata == 16'h0000)
      else $error("read data not zero outside a read");
   a_status_range: assert property (reg_read && reg_addr == `TDL_A_STATUS
      |=> reg_rdata <= 16'h0003)
      else $error("status out of range");
   // stop needs one more edge before the state itself is idle
   a_status_idle: assert property (idle_reg && $past(idle_reg)
      && reg_read && reg_addr == `TDL_A_STATUS
      |=> reg_rdata == 16'h0000)
      else $error("status not idle after stop");
   a_wo_zero: assert property (reg_read && (reg_addr == `TDL_A_HDR
      || reg_addr == `TDL_A_SAMPLE || reg_addr == `TDL_A_FCOUNT)
      |=> reg_rdata == 16'h0000)
      else $error("write-only register read back nonzero");
   a_hdr_size: assert property (lk_reg == 2'h1 && reg_read
      && reg_addr == `TDL_A_WIN + 9 |=> reg_rdata == `TDL_SWORDS)
      else $error("header words per sample wrong");
   a_sel_empty: assert property (lk_reg == 2'h2 && win_rd
      |=> reg_rdata == 16'h0000)
      else $error("window not empty after sample beyond count");
   a_fcnt_none: assert property (lk_reg == 2'h3 && win_rd
      |=> reg_rdata == 16'h0000)
      else $error("window not empty after empty count request");
   a_irq_fault: assert property (|fault_pulse && en_reg[2]
      && !(reg_write && reg_addr == `TDL_A_EV_EN) |=> irq)
      else $error("fault pulse did not raise interrupt");
   a_irq_masked: assert property (en_reg == 3'h0
      && $past(en_reg) == 3'h0 |-> !irq)
      else $error("interrupt high while all masked");
   c_done: cover property (reg_read && reg_addr == `TDL_A_STATUS
      ##1 reg_rdata == 16'h0003);
   c_irq: cover property ($rose(irq));
   c_hdr: cover property (lk_reg == 2'h1 && win_rd);
endmodule

// ==== bench/testbench.sv ====
`timescale 1ns/1ns
`include "tdl_consts.svh"
module testbench;
   localparam int MS = 4;
   localparam logic [15:0] CA [9] = '{`TDL_A_MODE, `TDL_A_K1, `TDL_A_P1,
      `TDL_A_M1, `TDL_A_T1, `TDL_A_K2, `TDL_A_P2, `TDL_A_M2, `TDL_A_T2};
   localparam logic [15:0] RQ [4] = '{16'h1D00, 16'h0101, 16'h051B, 16'h0003};
   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic [15:0] reg_addr = 16'h0000;
   logic [15:0] reg_wdata = 16'h0000;
   logic        reg_write = 1'b0;
   logic        reg_read = 1'b0;
   logic [15:0] reg_rdata;
   logic [31:0] supply_fault_word = 32'h0;
   logic [15:0] dc_voltage = 16'h0000;
   logic [15:0] dc_current = 16'h0000;
   logic [28:0] fault_pulse = 29'h0;
   logic [31:0] time_stamp = 32'h0;
   logic [31:0] date_stamp = 32'h0;
   logic        irq;
   integer      seed = 32'hA3A5;
   int          bad_count = 0;
   int          num_checks = 0;
   logic [31:0] fw, dv, cf [9];
   logic [15:0] fc [29], h [12], sv [5], d, w, prev;
   logic [28:0] fp;
   int          lo;
   tdl_logger #(.MS_CYCLES(MS)) dut (.clk(clk), .reset(reset),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
      .reg_read(reg_read), .reg_rdata(reg_rdata),
      .supply_fault_word(supply_fault_word), .dc_voltage(dc_voltage),
      .dc_current(dc_current), .fault_pulse(fault_pulse),
      .time_stamp(time_stamp), .date_stamp(date_stamp), .irq(irq));
   always #5 clk = ~clk;
   // running count shows sample spacing and order
   always @(posedge clk) dc_current <= dc_current + 16'h0001;
   // ----------------------------------------
   // bus tasks and model
   // ----------------------------------------
   task automatic check(input string nm, input logic [15:0] e, g);
      num_checks++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [15:0] a, dat);
      @(posedge clk);
      reg_write <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= dat;
      @(posedge clk);
      reg_write <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, output logic [15:0] q);
      @(posedge clk);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_read <= 1'b0;
      #1 q = reg_rdata;
   endtask
   task automatic rc(input logic [15:0] a, e, input string nm);
      logic [15:0] q;
      rd(a, q);
      check(nm, e, q);
   endtask
   function automatic logic [31:0] mv(input logic [31:0] p, m);
      return ((p == 32'h1) ? fw : (p == 32'h3) ? dv : 32'h0) & m;
   endfunction
   function automatic bit hit(input logic [31:0] k, p, m, t);
      case (k[1:0])
         2'h0: return mv(p, m) < t;
         2'h1: return mv(p, m) > t;
         2'h2: return mv(p, m) == t;
         default: return mv(p, m) != t;
      endcase
   endfunction
   task automatic cfg();
      for (int i = 0; i < 9; i++) begin
         if (i == 3 || i == 4 || i == 7 || i == 8) begin
            wr(CA[i], cf[i][31:16]);
            wr(CA[i] + 16'h0001, cf[i][15:0]);
         end else begin
            wr(CA[i], cf[i][15:0]);
         end
      end
   endtask
   task automatic trig_case();
      bit h1, h2;
      logic [15:0] e;
      supply_fault_word <= fw;
      dc_voltage <= dv[15:0];
      cfg();
      h1 = hit(cf[1], cf[2], cf[3], cf[4]);
      h2 = hit(cf[5], cf[6], cf[7], cf[8]);
      case (cf[0][1:0])
         2'h0: e = 16'h0002;
         2'h1: e = h1 ? 16'h0003 : 16'h0001;
         2'h2: e = (h1 | h2) ? 16'h0003 : 16'h0001;
         default: e = (h1 & h2) ? 16'h0003 : 16'h0001;
      endcase
      wr(`TDL_A_START, 16'h0001);
      repeat (4) @(posedge clk);
      rc(`TDL_A_STATUS, e, "trigger status");
      wr(`TDL_A_START, 16'h0000);
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      foreach (fc[i]) fc[i] = 16'h0000;
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      for (int i = 0; i < 19; i++) begin
         rc(16'h9DEE + i[15:0], 16'h0000, "reset value");
         w = $random(seed);
         wr(16'h9DEE + i[15:0], w);
         rc(16'h9DEE + i[15:0], w, "readback");
      end
      rc(16'h0000, 16'h0000, "unmapped");
      rc(`TDL_A_HDR, 16'h0000, "write-only");
      wr(`TDL_A_POSTPCT, 16'h0000);
      wr(`TDL_A_PERIOD, 16'h0001);
      // overvoltage bit or voltage above 600.0 V in tenths
      cf = '{32'h2, 32'h2, 32'h1, 32'h400, 32'h400, 32'h1, 32'h3,
         32'hFFFFFFFF, 32'h1770};
      for (int j = 0; j < 3; j++) begin
         fw = (j == 2) ? 32'h400 : 32'h0;
         dv = (j == 1) ? 32'h1771 : 32'h1770;
         trig_case();
      end
      for (int n = 0; n < 40; n++) begin
         fw = $random(seed);
         dv = $random(seed) & 32'hFFFF;
         cf[0] = $random(seed) & 3;
         for (int u = 1; u < 9; u += 4) begin
            cf[u] = $random(seed) & 3;
            cf[u + 1] = ($random(seed) & 1) ? 32'h1 : 32'h3;
            cf[u + 2] = ($random(seed) & 1) ? 32'hFFFFFFFF : $random(seed);
            cf[u + 3] = ($random(seed) & 1) ? mv(cf[u + 1], cf[u + 2])
               : $random(seed);
         end
         trig_case();
      end
      // capture: half the log after an overvoltage trigger
      wr(`TDL_A_EV_CLR, 16'h0007);
      wr(`TDL_A_EV_EN, 16'h0002);
      cf = '{32'h1, 32'h2, 32'h1, 32'h400, 32'h400, 32'h0, 32'h0, 32'h0, 32'h0};
      cfg();
      wr(`TDL_A_POSTPCT, 16'h0032);
      h[8] = 16'h0010;
      h[9] = `TDL_SWORDS;
      h[10] = 16'h0001;
      h[11] = 16'h0008;
      for (int i = 0; i < 4; i++) begin
         h[i + 4] = $random(seed);
         wr(`TDL_A_SEL_LO + i[15:0], h[i + 4]);
      end
      fw = $random(seed) & 32'hFFFFFBFF;
      dv = $random(seed) & 32'hFFFF;
      {h[0], h[1], h[2], h[3]} = {$random(seed), $random(seed)};
      time_stamp <= {h[0], h[1]};
      date_stamp <= {h[2], h[3]};
      supply_fault_word <= fw;
      dc_voltage <= dv[15:0];
      wr(`TDL_A_START, 16'h0001);
      repeat (90) @(posedge clk);
      supply_fault_word <= fw | 32'h400;
      d = 16'h0000;
      for (int k = 0; k < 60 && d !== 16'h0003; k++) rd(`TDL_A_STATUS, d);
      check("done status", 16'h0003, d);
      if (d !== 16'h0003)
         end_of_test();
      check("irq done", 16'h0001, {15'h0, irq});
      wr(`TDL_A_HDR, 16'h0001);
      for (int i = 0; i < 12; i++)
         rc(`TDL_A_WIN + i[15:0], h[i], "header");
      for (int i = 0; i <= 16; i++) begin
         wr(`TDL_A_SAMPLE, i[15:0]);
         for (int j = 0; j < 5; j++) rd(`TDL_A_WIN + j[15:0], sv[j]);
         check("stale word", 16'h0000, sv[4]);
         if (i == 16)
            check("beyond count", 16'h0000, sv[0]);
         else begin
            check("fault high", fw[31:16], sv[0]);
            check("voltage", dv[15:0], sv[2]);
            if (i > 0)
               check("spacing", MS[15:0], sv[3] - prev);
            if (i < 7 || i > 7)
               check("post flag", {15'h0, i > 7}, {15'h0, sv[1][10]});
            prev = sv[3];
         end
      end
      wr(`TDL_A_EV_CLR, 16'h0002);
      #1 check("irq cleared", 16'h0000, {15'h0, irq});
      rc(`TDL_A_EV_STAT, 16'h0001, "event status");
      wr(`TDL_A_START, 16'h0000);
      rc(`TDL_A_STATUS, 16'h0000, "stopped");
      // enable first so the pulses themselves raise the interrupt
      wr(`TDL_A_EV_EN, 16'h0004);
      #1 check("irq quiet", 16'h0000, {15'h0, irq});
      for (int n = 0; n < 30; n++) begin
         fp = $random(seed);
         fault_pulse <= fp;
         for (int j = 0; j < 29; j++) fc[j] += {15'h0, fp[j]};
         @(posedge clk);
         fault_pulse <= 29'h0;
         @(posedge clk);
      end
      check("irq fault", 16'h0001, {15'h0, irq});
      foreach (RQ[r]) begin
         wr(`TDL_A_FCOUNT, RQ[r]);
         for (int i = 0; i < 29; i++) begin
            lo = RQ[r][7:0] + i;
            w = (i < RQ[r][15:8] && lo <= 28) ? fc[lo] : 16'h0000;
            rc(`TDL_A_WIN + i[15:0], w, "fault count");
         end
      end
      end_of_test();
   end
endmodule
bind tdl_logger tdl_assertions #(.MS_CYCLES(MS_CYCLES)) u_chk (.clk(clk),
   .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
   .supply_fault_word(supply_fault_word), .dc_voltage(dc_voltage),
   .dc_current(dc_current), .fault_pulse(fault_pulse),
   .time_stamp(time_stamp), .date_stamp(date_stamp), .irq(irq));
